// ==== core/scan_defs.svh ====
// constants for the fieldbus scan sequencer
`ifndef SCAN_DEFS_SVH
`define SCAN_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define NODES       8
`define NODE_W      3
`define ADDR_W      6
`define SLOTS       4
`define SLOT_W      6
`define ASM_W       24
`define TBL_W       16
`define TMO_W       10
`define EPR_W       16
`define NOP_MS_W    11
`define MS_CNT_W    14

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_NS      100
`define MS_NS       1000000
`define MS_CYCLES   ((`MS_NS + `CLK_NS - 1) / `CLK_NS)
`define NOP_MS      11'd2000
`define RST_TMO     10'h3E8
`define RST_EPR     16'h03E8

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define OFF_CTRL    8'h00
`define OFF_TMO     8'h04
`define OFF_EPR     8'h08
`define OFF_STATUS  8'h0C
`define OFF_LIST    8'h10
`define BLK_IN_DESC  3'h1
`define BLK_OUT_DESC 3'h2
`define BLK_BIT_OUT  3'h3
`define BLK_WORD_OUT 3'h4
`define BLK_BIT_IN   3'h5
`define BLK_WORD_IN  3'h6

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define CTRL_RUN    0
`define CTRL_OWN    6:1
`define CTRL_BAUD   8:7
`define SLOT_TYPE   1:0
`define SLOT_CNT    5:2
`define SIZE_FIELD  7:0
`define DATA_BITS   15:0
`define DATA_WORDS  31:16

`endif

// ==== core/scan_pkg.sv ====
// types shared by the fieldbus scan sequencer
`include "scan_defs.svh"

package scan_pkg;

	typedef enum logic [3:0] {
		MSG_NONE      = 4'h0,
		MSG_OPEN_UCMM = 4'h1,
		MSG_OPEN_GRP2 = 4'h2,
		MSG_OPEN_POLL = 4'h3,
		MSG_GET_PROD  = 4'h4,
		MSG_GET_CONS  = 4'h5,
		MSG_SET_EPR   = 4'h6,
		MSG_REL_EXPL  = 4'h7,
		MSG_REL_BOTH  = 4'h8,
		MSG_POLL      = 4'h9,
		MSG_NOP       = 4'hA
	} msg_t;

	typedef enum logic [1:0] {
		SLOT_NONE  = 2'h0,
		SLOT_BITS  = 2'h1,
		SLOT_WORDS = 2'h2
	} slot_t;

	typedef struct packed {
		logic                valid;
		logic [`ADDR_W-1:0]  addr;
		msg_t                kind;
		logic [31:0]         data;
	} req_t;

	typedef struct packed {
		logic                valid;
		logic [`ADDR_W-1:0]  addr;
		msg_t                kind;
		logic                ok;
		logic [31:0]         data;
	} rsp_t;

	typedef struct packed {
		logic                               run;
		logic [`ADDR_W-1:0]                 own_addr;
		logic [1:0]                         baud;
		logic [`TMO_W-1:0]                  tmo_ms;
		logic [`EPR_W-1:0]                  epr_ms;
		logic [`NODES-1:0]                  in_list;
		logic [`NODES-1:0][`ASM_W-1:0]      in_desc;
		logic [`NODES-1:0][`ASM_W-1:0]      out_desc;
		logic [`NODES-1:0][`TBL_W-1:0]      bit_out;
		logic [`NODES-1:0][`TBL_W-1:0]      word_out;
		logic [`NODES-1:0][`TBL_W-1:0]      bit_in;
		logic [`NODES-1:0][`TBL_W-1:0]      word_in;
		logic [`NODES-1:0]                  online;
		logic [`NODES-1:0]                  pending;
		logic [`NODES-1:0]                  nop_due;
		msg_t [`NODES-1:0]                  step;
		msg_t [`NODES-1:0]                  cur;
		logic [`NODES-1:0][`TMO_W-1:0]      timer;
		logic [`NODE_W-1:0]                 ptr;
		logic [`MS_CNT_W-1:0]               ms_cnt;
		logic [`NOP_MS_W-1:0]               nop_cnt;
		req_t                               req;
		logic                               wr_pend;
		logic [7:0]                         wr_addr;
		logic [31:0]                        rdata;
	} state_t;

endpackage

// ==== core/fieldbus_scanner.sv ====
// fieldbus scan sequencer with AHB-Lite register slave
`timescale 1ns/1ps
`include "scan_defs.svh"

module fieldbus_scanner #(
	parameter int MS_CYCLES = `MS_CYCLES
) (
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire logic            ce,
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic [31:0]          hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	output scan_pkg::req_t       msg_req,
	input  wire logic            msg_req_ready,
	input  wire scan_pkg::rsp_t  msg_rsp,
	output logic [1:0]           baud_sel,
	output logic [`NODES-1:0]    node_online
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	scan_pkg::state_t    s_r;
	scan_pkg::state_t    s_nxt;
	logic                visit;
	logic                issue;
	logic                rsp_take;
	logic [`NODE_W-1:0]  rsp_idx;

	// slot sizes in bytes
	function automatic logic [7:0] asm_bytes(input logic [`ASM_W-1:0] d);
		logic [7:0]         sum;
		logic [`SLOT_W-1:0] sl;
		sum = 8'h00;
		for (int j = 0; j < `SLOTS; j++) begin
			sl = d[j*`SLOT_W +: `SLOT_W];
			if (sl[`SLOT_TYPE] == scan_pkg::SLOT_BITS) begin
				sum = sum + {4'h0, sl[`SLOT_CNT]};
			end else if (sl[`SLOT_TYPE] == scan_pkg::SLOT_WORDS) begin
				sum = sum + {3'h0, sl[`SLOT_CNT], 1'b0};
			end
		end
		return sum;
	endfunction

	assign rsp_idx  = msg_rsp.addr[`NODE_W-1:0];
	assign rsp_take = msg_rsp.valid && (msg_rsp.addr < `ADDR_W'(`NODES)) &&
	                  s_r.pending[rsp_idx] && (msg_rsp.kind == s_r.cur[rsp_idx]);
	assign visit    = ce && s_r.run && !s_r.req.valid;
	assign issue    = visit && s_nxt.req.valid;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic               tick;
		logic [`NODE_W-1:0] p;
		logic [2:0]         blk;
		logic [`NODE_W-1:0] idx;
		scan_pkg::msg_t     k;
		s_nxt = s_r;
		tick  = (s_r.ms_cnt == `MS_CNT_W'(MS_CYCLES - 1));
		p     = s_r.ptr;
		blk   = s_r.wr_addr[7:5];
		idx   = s_r.wr_addr[4:2];
		k     = scan_pkg::MSG_NONE;

		// millisecond base and no-op period
		s_nxt.ms_cnt = tick ? '0 : s_r.ms_cnt + 1'b1;
		if (tick) begin
			if (s_r.nop_cnt == `NOP_MS - 1'b1) begin
				s_nxt.nop_cnt = '0;
				s_nxt.nop_due = s_r.nop_due | s_r.online;
			end else begin
				s_nxt.nop_cnt = s_r.nop_cnt + 1'b1;
			end
		end

		// bus write data phase
		s_nxt.wr_pend = 1'b0;
		if (s_r.wr_pend) begin
			if (s_r.wr_addr == `OFF_CTRL) begin
				s_nxt.run      = hwdata[`CTRL_RUN];
				s_nxt.own_addr = hwdata[`CTRL_OWN];
				s_nxt.baud     = hwdata[`CTRL_BAUD];
			end else if (s_r.wr_addr == `OFF_TMO) begin
				s_nxt.tmo_ms = hwdata[`TMO_W-1:0];
			end else if (s_r.wr_addr == `OFF_EPR) begin
				s_nxt.epr_ms = hwdata[`EPR_W-1:0];
			end else if (s_r.wr_addr == `OFF_LIST) begin
				s_nxt.in_list = hwdata[`NODES-1:0];
			end else if (blk == `BLK_IN_DESC) begin
				s_nxt.in_desc[idx] = hwdata[`ASM_W-1:0];
			end else if (blk == `BLK_OUT_DESC) begin
				s_nxt.out_desc[idx] = hwdata[`ASM_W-1:0];
			end else if (blk == `BLK_BIT_OUT) begin
				s_nxt.bit_out[idx] = hwdata[`TBL_W-1:0];
			end else if (blk == `BLK_WORD_OUT) begin
				s_nxt.word_out[idx] = hwdata[`TBL_W-1:0];
			end
		end

		// link request accepted
		if (s_r.req.valid && msg_req_ready) begin
			s_nxt.req.valid = 1'b0;
		end

		// response timers
		for (int i = 0; i < `NODES; i++) begin
			if (s_r.pending[i]) begin
				if (tick) begin
					s_nxt.timer[i] = s_r.timer[i] + 1'b1;
				end
				if (s_r.tmo_ms != '0 && s_r.timer[i] >= s_r.tmo_ms) begin
					s_nxt.pending[i] = 1'b0;
					s_nxt.online[i]  = 1'b0;
					s_nxt.step[i]    = scan_pkg::MSG_NONE;
				end
			end
		end

		// responses, per node
		if (rsp_take) begin
			s_nxt.pending[rsp_idx] = 1'b0;
			case (s_r.cur[rsp_idx])
				scan_pkg::MSG_OPEN_UCMM: begin
					s_nxt.step[rsp_idx] = msg_rsp.ok ? scan_pkg::MSG_OPEN_POLL
					                                 : scan_pkg::MSG_OPEN_GRP2;
				end
				scan_pkg::MSG_OPEN_GRP2: begin
					s_nxt.step[rsp_idx] = msg_rsp.ok ? scan_pkg::MSG_OPEN_POLL
					                                 : scan_pkg::MSG_NONE;
				end
				scan_pkg::MSG_OPEN_POLL: begin
					s_nxt.step[rsp_idx] = msg_rsp.ok ? scan_pkg::MSG_GET_PROD
					                                 : scan_pkg::MSG_REL_EXPL;
				end
				scan_pkg::MSG_GET_PROD: begin
					if (msg_rsp.ok && msg_rsp.data[`SIZE_FIELD] ==
					    asm_bytes(s_r.in_desc[rsp_idx])) begin
						s_nxt.step[rsp_idx] = scan_pkg::MSG_GET_CONS;
					end else begin
						s_nxt.step[rsp_idx] = scan_pkg::MSG_REL_BOTH;
					end
				end
				scan_pkg::MSG_GET_CONS: begin
					if (msg_rsp.ok && msg_rsp.data[`SIZE_FIELD] ==
					    asm_bytes(s_r.out_desc[rsp_idx])) begin
						s_nxt.step[rsp_idx] = scan_pkg::MSG_SET_EPR;
					end else begin
						s_nxt.step[rsp_idx] = scan_pkg::MSG_REL_BOTH;
					end
				end
				scan_pkg::MSG_SET_EPR: begin
					if (msg_rsp.ok) begin
						s_nxt.online[rsp_idx]  = 1'b1;
						s_nxt.nop_due[rsp_idx] = 1'b0;
						s_nxt.step[rsp_idx]    = scan_pkg::MSG_NONE;
					end else begin
						s_nxt.step[rsp_idx] = scan_pkg::MSG_REL_BOTH;
					end
				end
				scan_pkg::MSG_POLL: begin
					if (msg_rsp.ok) begin
						s_nxt.bit_in[rsp_idx]  = msg_rsp.data[`DATA_BITS];
						s_nxt.word_in[rsp_idx] = msg_rsp.data[`DATA_WORDS];
					end
				end
				scan_pkg::MSG_NOP: begin
					s_nxt.step[rsp_idx] = s_r.step[rsp_idx];
				end
				default: begin
					s_nxt.step[rsp_idx] = scan_pkg::MSG_NONE;
				end
			endcase
		end

		// scan walk
		if (visit) begin
			s_nxt.ptr = p + 1'b1;
			if (s_r.in_list[p] && !s_r.pending[p] &&
			    {{(`ADDR_W-`NODE_W){1'b0}}, p} != s_r.own_addr) begin
				if (!s_r.online[p]) begin
					k = (s_r.step[p] == scan_pkg::MSG_NONE) ? scan_pkg::MSG_OPEN_UCMM
					                                        : s_r.step[p];
				end else if (s_r.nop_due[p]) begin
					k = scan_pkg::MSG_NOP;
					s_nxt.nop_due[p] = tick && (s_r.nop_cnt == `NOP_MS - 1'b1);
				end else begin
					k = scan_pkg::MSG_POLL;
				end
				s_nxt.req.valid  = 1'b1;
				s_nxt.req.addr   = {{(`ADDR_W-`NODE_W){1'b0}}, p};
				s_nxt.req.kind   = k;
				s_nxt.pending[p] = 1'b1;
				s_nxt.cur[p]     = k;
				s_nxt.timer[p]   = '0;
				if (k == scan_pkg::MSG_SET_EPR) begin
					s_nxt.req.data = {16'h0000, s_r.epr_ms};
				end else if (k == scan_pkg::MSG_POLL) begin
					s_nxt.req.data = {s_r.word_out[p], s_r.bit_out[p]};
				end else begin
					s_nxt.req.data = 32'h0000_0000;
				end
			end
		end

		// bus address phase
		if (hsel && htrans[1] && hready && hwrite && haddr[31:8] == 24'h000000) begin
			s_nxt.wr_pend = 1'b1;
			s_nxt.wr_addr = haddr[7:0];
		end
		s_nxt.rdata = 32'h0000_0000;
		if (hsel && htrans[1] && hready && !hwrite && haddr[31:8] == 24'h000000) begin
			if (haddr[7:0] == `OFF_CTRL) begin
				s_nxt.rdata[`CTRL_RUN]  = s_nxt.run;
				s_nxt.rdata[`CTRL_OWN]  = s_nxt.own_addr;
				s_nxt.rdata[`CTRL_BAUD] = s_nxt.baud;
			end else if (haddr[7:0] == `OFF_TMO) begin
				s_nxt.rdata[`TMO_W-1:0] = s_nxt.tmo_ms;
			end else if (haddr[7:0] == `OFF_EPR) begin
				s_nxt.rdata[`EPR_W-1:0] = s_nxt.epr_ms;
			end else if (haddr[7:0] == `OFF_STATUS) begin
				s_nxt.rdata[2*`NODES-1:0] = {s_nxt.pending, s_nxt.online};
			end else if (haddr[7:0] == `OFF_LIST) begin
				s_nxt.rdata[`NODES-1:0] = s_nxt.in_list;
			end else if (haddr[7:5] == `BLK_IN_DESC) begin
				s_nxt.rdata[`ASM_W-1:0] = s_nxt.in_desc[haddr[4:2]];
			end else if (haddr[7:5] == `BLK_OUT_DESC) begin
				s_nxt.rdata[`ASM_W-1:0] = s_nxt.out_desc[haddr[4:2]];
			end else if (haddr[7:5] == `BLK_BIT_OUT) begin
				s_nxt.rdata[`TBL_W-1:0] = s_nxt.bit_out[haddr[4:2]];
			end else if (haddr[7:5] == `BLK_WORD_OUT) begin
				s_nxt.rdata[`TBL_W-1:0] = s_nxt.word_out[haddr[4:2]];
			end else if (haddr[7:5] == `BLK_BIT_IN) begin
				s_nxt.rdata[`TBL_W-1:0] = s_nxt.bit_in[haddr[4:2]];
			end else if (haddr[7:5] == `BLK_WORD_IN) begin
				s_nxt.rdata[`TBL_W-1:0] = s_nxt.word_in[haddr[4:2]];
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r        <= '0;
			s_r.tmo_ms <= `RST_TMO;
			s_r.epr_ms <= `RST_EPR;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign hrdata      = s_r.rdata;
	assign hreadyout   = 1'b1;
	assign hresp       = 1'b0;
	assign msg_req     = s_r.req;
	assign baud_sel    = s_r.baud;
	assign node_online = s_r.online;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_ucmm_fail;
		ce && rsp_take && msg_rsp.kind == scan_pkg::MSG_OPEN_UCMM && !msg_rsp.ok;
	endsequence

	sequence s_prod_bad;
		ce && rsp_take && msg_rsp.kind == scan_pkg::MSG_GET_PROD &&
		(!msg_rsp.ok || msg_rsp.data[`SIZE_FIELD] != asm_bytes(s_r.in_desc[rsp_idx]));
	endsequence

	sequence s_poll_ok;
		ce && rsp_take && msg_rsp.kind == scan_pkg::MSG_POLL && msg_rsp.ok;
	endsequence

	property p_ucmm_fallback;
		logic [`NODE_W-1:0] i;
		@(posedge hclk) disable iff (!hresetn)
		(s_ucmm_fail, i = rsp_idx) |=> s_r.step[i] == scan_pkg::MSG_OPEN_GRP2;
	endproperty

	property p_prod_release;
		logic [`NODE_W-1:0] i;
		@(posedge hclk) disable iff (!hresetn)
		(s_prod_bad, i = rsp_idx) |=> s_r.step[i] == scan_pkg::MSG_REL_BOTH;
	endproperty

	property p_poll_store;
		logic [`NODE_W-1:0] i;
		logic [31:0]        d;
		@(posedge hclk) disable iff (!hresetn)
		(s_poll_ok, i = rsp_idx, d = msg_rsp.data) |=>
			s_r.bit_in[i] == d[`DATA_BITS] && s_r.word_in[i] == d[`DATA_WORDS];
	endproperty

	a_ptr_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
		visit && s_r.ptr == `NODE_W'(`NODES - 1) |=> s_r.ptr == '0)
		else $error("scan pointer did not wrap");

	a_ptr_ascend: assert property (@(posedge hclk) disable iff (!hresetn)
		visit |=> s_r.ptr == `NODE_W'($past(s_r.ptr) + 1'b1))
		else $error("scan pointer not ascending");

	a_issue_pending: assert property (@(posedge hclk) disable iff (!hresetn)
		issue |=> s_r.pending[$past(s_r.ptr)] && s_r.req.valid)
		else $error("issued node not marked outstanding");

	a_poll_online: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(s_r.req.valid) && s_r.req.kind == scan_pkg::MSG_POLL |->
			s_r.online[s_r.req.addr[`NODE_W-1:0]] && $past(s_r.run))
		else $error("poll sent to node not online");

	a_offline_estab: assert property (@(posedge hclk) disable iff (!hresetn)
		issue && !s_r.online[s_r.ptr] |=>
			!(s_r.req.kind inside {scan_pkg::MSG_POLL, scan_pkg::MSG_NOP}))
		else $error("offline node got data traffic");

	a_ucmm_grp2: assert property (p_ucmm_fallback)
		else $error("no group 2 retry after failed open");

	a_prod_release: assert property (p_prod_release)
		else $error("bad production size not released");

	a_online_epr: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_r.online & ~$past(s_r.online)) != '0 |->
			$past(rsp_take && msg_rsp.kind == scan_pkg::MSG_SET_EPR && msg_rsp.ok))
		else $error("node online without rate set");

	a_poll_store: assert property (p_poll_store)
		else $error("poll response not stored");

	a_nop_online: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(s_r.req.valid) && s_r.req.kind == scan_pkg::MSG_NOP |->
			s_r.online[s_r.req.addr[`NODE_W-1:0]])
		else $error("no-op sent to node not online");

	genvar g;
	generate
		for (g = 0; g < `NODES; g++) begin : gen_tmo
			a_tmo_drop: assert property (@(posedge hclk) disable iff (!hresetn)
				ce && s_r.pending[g] && s_r.tmo_ms != '0 && s_r.timer[g] >= s_r.tmo_ms &&
				!(rsp_take && rsp_idx == g) |=> !s_r.online[g] && !s_r.pending[g])
				else $error("timeout did not drop node");
		end
	endgenerate

endmodule

// ==== test/node_model.sv ====
// slave node partner model answering the scan sequencer's message requests
`timescale 1ns/1ps
module node_model (
	input  wire logic           hclk,
	input  wire logic           hresetn,
	input  wire scan_pkg::req_t msg_req,
	output logic                msg_req_ready,
	output scan_pkg::rsp_t      msg_rsp,
	input  wire logic           stall,
	input  wire logic [3:0]     fail_kind,
	input  wire logic [5:0]     fail_addr,
	input  wire logic           drop,
	input  wire logic [7:0]     prod_size,
	input  wire logic [7:0]     cons_size,
	input  wire logic [31:0]    poll_data
);
	scan_pkg::rsp_t pipe [4];
	scan_pkg::rsp_t nr;
	logic [31:0]    junk;

	assign msg_req_ready = msg_req.valid & ~stall;
	assign msg_rsp       = pipe[3];

	// ----------------------------------------------------------------
	// answer, four cycles after acceptance
	// ----------------------------------------------------------------
	always_comb begin
		nr       = '0;
		nr.valid = msg_req_ready & ~(drop & (msg_req.addr == fail_addr));
		nr.addr  = msg_req.addr;
		nr.kind  = msg_req.kind;
		nr.ok    = ~((msg_req.kind == fail_kind) && (msg_req.addr == fail_addr));
		case (msg_req.kind)
			scan_pkg::MSG_GET_PROD: nr.data = {24'h0, prod_size};
			scan_pkg::MSG_GET_CONS: nr.data = {24'h0, cons_size};
			scan_pkg::MSG_POLL:     nr.data = poll_data;
			default:                nr.data = junk;
		endcase
		if (!nr.valid) begin
			nr.data = junk;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 4; i++) pipe[i] <= '0;
			junk <= 32'h0;
		end else begin
			junk    <= ~junk + 32'h1;
			pipe[0] <= nr;
			for (int i = 1; i < 4; i++) pipe[i] <= pipe[i-1];
		end
	end
endmodule

// ==== test/fieldbus_scanner_test.sv ====
// self-checking bench for the fieldbus scan sequencer
`timescale 1ns/1ps
module fieldbus_scanner_test;
	logic           hclk, hresetn, hsel, hwrite, hreadyout, hresp, msg_req_ready;
	logic           stall, drop, multi;
	logic [1:0]     htrans, baud_sel;
	logic [31:0]    haddr, hwdata, hrdata, poll_data, rd, edat;
	logic [7:0]     node_online, prod_size, cons_size, outst;
	logic [3:0]     fail_kind;
	logic [5:0]     fail_addr;
	scan_pkg::req_t msg_req;
	scan_pkg::rsp_t msg_rsp;
	int             miscompares, samples_checked, nops;
	logic [3:0]     seen [8][$];
	int             ord [$];
	logic [31:0]    pdat [8];

	fieldbus_scanner #(.MS_CYCLES(4)) DUT (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .msg_req(msg_req), .msg_req_ready(msg_req_ready),
		.msg_rsp(msg_rsp), .baud_sel(baud_sel), .node_online(node_online));
	node_model partner (.hclk(hclk), .hresetn(hresetn), .msg_req(msg_req),
		.msg_req_ready(msg_req_ready), .msg_rsp(msg_rsp), .stall(stall),
		.fail_kind(fail_kind), .fail_addr(fail_addr), .drop(drop),
		.prod_size(prod_size), .cons_size(cons_size), .poll_data(poll_data));

	always #50 hclk = ~hclk;

	// ----------------------------------------------------------------
	// link monitor
	// ----------------------------------------------------------------
	always @(posedge hclk) begin
		if (hresetn && msg_rsp.valid) outst[msg_rsp.addr[2:0]] <= 1'b0;
		if (hresetn && msg_req.valid && msg_req_ready) begin
			if (outst[msg_req.addr[2:0]] && !drop) chk("overlap", 0, 1);
			if (|(outst & ~(8'h1 << msg_req.addr[2:0]))) multi <= 1'b1;
			if (!drop) outst[msg_req.addr[2:0]] <= 1'b1;
			if (msg_req.kind == scan_pkg::MSG_SET_EPR) edat <= msg_req.data;
			if (msg_req.kind == scan_pkg::MSG_NOP) nops++;
			seen[msg_req.addr[2:0]].push_back(msg_req.kind);
			ord.push_back(int'(msg_req.addr));
			pdat[msg_req.addr[2:0]] <= msg_req.data;
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic stuck(input int n, input int lim);
		if (n >= lim) begin
			chk("wait bound", 0, 1);
			complete_run();
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int   n;
		logic ok;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do begin
			@(posedge hclk);
			ok = hreadyout;
			n++;
		end while (ok !== 1'b1 && n < 64);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge hclk);
			ok = hreadyout;
			rd = hrdata;
			n++;
		end while (ok !== 1'b1 && n < 64);
		stuck(n, 64);
	endtask

	task automatic do_reset;
		hresetn <= 1'b0;
		repeat (20) @(posedge hclk);
		for (int i = 0; i < 8; i++) seen[i].delete();
		ord.delete();
		outst <= 8'h0;
		multi <= 1'b0;
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask

	task automatic cfg(input int n);
		ahb(1, 8'(32'h20 + 4 * n), 32'h500185);
		ahb(1, 8'(32'h40 + 4 * n), 32'h006009);
	endtask

	function automatic logic [31:0] seqv(input int a, input int k);
		logic [31:0] v;
		v = '0;
		for (int j = 0; j < k; j++) v = {v[27:0], seen[a][j]};
		return v;
	endfunction

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		ahb(0, 8'h00, 0); chk("ctrl", 0, rd);
		ahb(0, 8'h04, 0); chk("tmo", 32'h3E8, rd);
		ahb(0, 8'h08, 0); chk("epr", 32'h3E8, rd);
		ahb(1, 8'h0C, 32'hFFFF); ahb(0, 8'h0C, 0); chk("status", 0, rd);
		ahb(1, 8'hFC, 32'h5A5A); ahb(0, 8'hFC, 0); chk("unmapped", 0, rd);
		ahb(1, 8'h00, 32'h182); ahb(0, 8'h00, 0); chk("ctrl", 32'h182, rd);
		chk("baud", 32'h3, baud_sel);
	endtask

	task automatic t_connect;
		int n;
		prod_size <= 8'h03;
		cons_size <= 8'h04;
		cfg(2);
		cfg(5);
		ahb(1, 8'h10, 32'h26);
		ahb(1, 8'h00, 32'h183);
		for (n = 0; (node_online !== 8'h24 || seen[2].size() < 6) && n < 600; n++) @(posedge hclk);
		stuck(n, 600);
		chk("online", 8'h24, node_online);
		chk("order", 2, ord[0]);
		chk("order", 5, ord[1]);
		chk("multi", 1, multi);
		chk("own skipped", 0, seen[1].size());
		chk("steps", 32'h134569, seqv(2, 6));
		chk("epr data", 32'h3E8, edat);
	endtask

	task automatic t_poll;
		int n, m;
		poll_data <= 32'hBEEF1234;
		ahb(1, 8'h68, 32'hA55A);
		ahb(1, 8'h88, 32'h1357);
		m = seen[2].size();
		for (n = 0; seen[2].size() < m + 3 && n < 400; n++) @(posedge hclk);
		stuck(n, 400);
		repeat (8) @(posedge hclk);
		chk("poll cmd", 32'h1357A55A, pdat[2]);
		ahb(0, 8'hA8, 0); chk("bit in", 32'h1234, rd);
		ahb(0, 8'hC8, 0); chk("word in", 32'hBEEF, rd);
		chk("wrap", 1, seen[5].size() > 7);
	endtask

	task automatic t_nop;
		int n;
		for (n = 0; nops < 2 && n < 9000; n++) @(posedge hclk);
		stuck(n, 9000);
		chk("nop", 1, nops >= 2);
	endtask

	task automatic t_timeout;
		int n, m;
		ahb(1, 8'h04, 32'h3);
		fail_addr <= 6'h2;
		drop <= 1'b1;
		for (n = 0; node_online[2] !== 1'b0 && n < 200; n++) @(posedge hclk);
		stuck(n, 200);
		chk("dropped", 8'h20, node_online);
		drop <= 1'b0;
		@(posedge hclk);
		outst[2] <= 1'b0;
		m = seen[2].size();
		for (n = 0; seen[2].size() <= m && n < 200; n++) @(posedge hclk);
		stuck(n, 200);
		chk("reopen", 1, seen[2][m]);
	endtask

	task automatic t_fail;
		logic [3:0]  fk [7] = '{1, 3, 4, 0, 5, 0, 6};
		logic [7:0]  pz [7] = '{3, 3, 3, 2, 3, 3, 3};
		logic [7:0]  cz [7] = '{4, 4, 4, 4, 4, 5, 4};
		int          ln [7] = '{3, 4, 5, 5, 6, 6, 7};
		logic [31:0] sq [7] = '{32'h123, 32'h1371, 32'h13481, 32'h13481,
			32'h134581, 32'h134581, 32'h1345681};
		int          n;
		for (int i = 0; i < 7; i++) begin
			do_reset();
			fail_kind <= fk[i];
			fail_addr <= 6'h3;
			prod_size <= pz[i];
			cons_size <= cz[i];
			cfg(3);
			ahb(1, 8'h10, 32'h08);
			ahb(1, 8'h00, 32'h001);
			for (n = 0; seen[3].size() < ln[i] && n < 600; n++) @(posedge hclk);
			stuck(n, 600);
			chk("fail seq", sq[i], seqv(3, ln[i]));
			chk("offline", 0, node_online);
		end
	endtask

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		stall = 1'b0;
		drop = 1'b0;
		fail_kind = 4'h0;
		fail_addr = 6'h0;
		prod_size = 8'h0;
		cons_size = 8'h0;
		poll_data = 32'h0;
		outst = 8'h0;
		multi = 1'b0;
		do_reset();
		t_regs();
		t_connect();
		t_poll();
		t_nop();
		t_timeout();
		t_fail();
		complete_run();
	end
endmodule
